/* File: include/thh_pkg.sv */
// Constants shared by the test head host interface and its message memory.
// Assumes a single clock domain; all widths are fixed.
package thh_pkg;

    // ------------------------------------------------------------------
    // pcm window layout
    // ------------------------------------------------------------------
    localparam int PCM_SLOTS = 8; // one slot per codec
    localparam logic [3:0] PCM_KEEP_BITS = 4'h8; // sample bits kept per slot
    localparam logic [3:0] PCM_SLOT_LAST = 4'h9; // last of the 10 slot bits
    localparam logic [2:0] PCM_LAST_SLOT = 3'h7;
    localparam logic PCM_IDLE_BIT = 1'b1; // bit sent for a muted loop

    // ------------------------------------------------------------------
    // message memory
    // ------------------------------------------------------------------
    localparam int RAM_AW = 11; // 2048 bytes
    localparam int RAM_DW = 8;
    localparam int RAM_DEPTH = 2048;

    typedef enum logic [3:0] {
        ARB_IDLE = 4'h1,
        ARB_WAIT = 4'h2,
        ARB_ACCESS = 4'h4,
        ARB_DONE = 4'h8
    } thh_arb_t;

    // ------------------------------------------------------------------
    // paddle board latches
    // ------------------------------------------------------------------
    localparam logic [2:0] IO_HOOK = 3'h0; // offhook per loop
    localparam logic [2:0] IO_GROUND = 3'h1; // ground apply per loop
    localparam logic [2:0] IO_TXMUTE = 3'h2; // transmit disable per loop
    localparam logic [2:0] IO_MON_LO = 3'h3; // monitor select loops 0..3
    localparam logic [2:0] IO_MON_HI = 3'h4; // monitor select loops 4..7
    localparam logic [7:0] HOOK_RST = 8'h00;
    localparam logic [7:0] GROUND_RST = 8'h00;
    localparam logic [7:0] TXMUTE_RST = 8'h00;
    localparam logic [15:0] MON_RST = 16'h0000;

    localparam logic [1:0] MON_TR = 2'h0; // tip to ring
    localparam logic [1:0] MON_TG = 2'h1; // tip to ground
    localparam logic [1:0] MON_RG = 2'h2; // ring to ground

endpackage

/* File: rtl/thh_msg_ram.sv */
// Dual-port byte memory for host and microcontroller messages.
// Assumes the arbiter never lets both ports touch one address together.
`timescale 1ns/1ps
`default_nettype none
module thh_msg_ram
    import thh_pkg::*;
(
    input wire logic clk,
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [RAM_AW-1:0] a_addr,
    input wire logic [RAM_DW-1:0] a_wdata,
    output logic [RAM_DW-1:0] a_rdata,
    input wire logic b_en,
    input wire logic b_we,
    input wire logic [RAM_AW-1:0] b_addr,
    input wire logic [RAM_DW-1:0] b_wdata,
    output logic [RAM_DW-1:0] b_rdata
);

    logic [RAM_DW-1:0] mem [RAM_DEPTH];

    // both ports work in the same cycle; read data is registered
    always_ff @(posedge clk) begin
        if (a_en) begin
            if (a_we) begin
                mem[a_addr] <= a_wdata;
            end
            a_rdata <= mem[a_addr];
        end
        if (b_en) begin
            if (b_we) begin
                mem[b_addr] <= b_wdata;
            end
            b_rdata <= mem[b_addr];
        end
    end

endmodule // thh_msg_ram
`default_nettype wire

/* File: rtl/thh_top.sv */
// Test head host interface: pcm slot splitter, shared message memory
// with arbitration, paddle board latches and ringing monitor select.
// Assumes all inputs synchronous to MCLK; PCM_BIT_EN marks each pcm bit.
`timescale 1ns/1ps
`default_nettype none
module thh_top
    import thh_pkg::*;
#(
    parameter logic [7:0] BOARD_ID = 8'h5A // arbitrary identity value
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic PCM_BIT_EN,
    input wire logic PCM_FRAME_WINDOW_N,
    input wire logic PCM_INBOUND_STREAM,
    output logic PCM_OUTBOUND_DATA,
    output logic PCM_OUTBOUND_OE,
    output logic [7:0] CODEC_SLOT_ENABLE,
    output logic CODEC_RX_DATA,
    input wire logic [7:0] CODEC_TX_DATA,
    input wire logic HOST_REQ,
    input wire logic HOST_WE,
    input wire logic [10:0] HOST_ADDR,
    input wire logic [7:0] HOST_WDATA,
    output logic [7:0] HOST_RDATA,
    output logic HOST_RAM_HANDSHAKE,
    input wire logic MCU_REQ,
    input wire logic MCU_WE,
    input wire logic [10:0] MCU_ADDR,
    input wire logic [7:0] MCU_WDATA,
    output logic [7:0] MCU_RDATA,
    output logic MCU_ACK,
    input wire logic IO_RD,
    input wire logic IO_WR,
    input wire logic [2:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    output logic IO_RDATA_OE,
    output logic [7:0] RELAY_HOOK,
    output logic [7:0] RELAY_GROUND,
    output logic [15:0] RING_MON_SEL,
    input wire logic [7:0] RING_TR,
    input wire logic [7:0] RING_TG,
    input wire logic [7:0] RING_RG,
    output logic [7:0] RING_DETECT
);

    import thh_pkg::*;

    // ------------------------------------------------------------------
    // pcm window splitter
    // ------------------------------------------------------------------
    logic [2:0] slot, next_slot;
    logic [3:0] pos, next_pos;
    logic over, next_over;
    logic [7:0] slot_en, next_slot_en;
    logic rx_bit, next_rx_bit;
    logic tx_bit, next_tx_bit;
    logic tx_oe, next_tx_oe;
    logic [7:0] txmute;

    // walk the window ten bits per slot, eight of them used
    always_comb begin
        next_slot = slot;
        next_pos = pos;
        next_over = over;
        next_slot_en = slot_en;
        next_rx_bit = rx_bit;
        next_tx_bit = tx_bit;
        next_tx_oe = tx_oe;
        if (PCM_FRAME_WINDOW_N) begin
            next_slot = 3'h0;
            next_pos = 4'h0;
            next_over = 1'b0;
            next_slot_en = 8'h00;
            next_rx_bit = 1'b0;
            next_tx_bit = 1'b0;
            next_tx_oe = 1'b0;
        end else if (PCM_BIT_EN) begin
            next_slot_en = 8'h00;
            next_rx_bit = 1'b0;
            next_tx_bit = 1'b0;
            next_tx_oe = 1'b0;
            if (!over && pos < PCM_KEEP_BITS) begin
                next_slot_en[slot] = 1'b1;
                next_rx_bit = PCM_INBOUND_STREAM;
                next_tx_oe = 1'b1;
                // muted loop sends idle bits instead of audio
                next_tx_bit = txmute[slot] ? PCM_IDLE_BIT
                                           : CODEC_TX_DATA[slot];
            end
            if (pos == PCM_SLOT_LAST) begin
                next_pos = 4'h0;
                next_slot = 3'(slot + 3'h1);
                if (slot == PCM_LAST_SLOT) begin
                    next_over = 1'b1; // bits past 80 are ignored
                end
            end else begin
                next_pos = 4'(pos + 4'h1);
            end
        end
    end

    // pcm registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            slot <= 3'h0;
            pos <= 4'h0;
            over <= 1'b0;
            slot_en <= 8'h00;
            rx_bit <= 1'b0;
            tx_bit <= 1'b0;
            tx_oe <= 1'b0;
        end else begin
            slot <= next_slot;
            pos <= next_pos;
            over <= next_over;
            slot_en <= next_slot_en;
            rx_bit <= next_rx_bit;
            tx_bit <= next_tx_bit;
            tx_oe <= next_tx_oe;
        end
    end

    assign CODEC_SLOT_ENABLE = slot_en;
    assign CODEC_RX_DATA = rx_bit;
    assign PCM_OUTBOUND_DATA = tx_bit;
    assign PCM_OUTBOUND_OE = tx_oe;

    // ------------------------------------------------------------------
    // message memory arbiter, port 0 host, port 1 microcontroller
    // ------------------------------------------------------------------
    thh_arb_t st [2];
    thh_arb_t next_st [2];
    logic sen_mcu, next_sen_mcu;
    logic [1:0] req, want, acc, wt, grant;
    logic same, mcu_first;

    // first come first served per address, host wins ties
    always_comb begin
        req = {MCU_REQ, HOST_REQ};
        same = (HOST_ADDR == MCU_ADDR);
        for (int p = 0; p < 2; p++) begin
            want[p] = (st[p] == ARB_IDLE && req[p]) || st[p] == ARB_WAIT;
            acc[p] = (st[p] == ARB_ACCESS);
            wt[p] = (st[p] == ARB_WAIT);
        end
        mcu_first = wt[1] && (!wt[0] || sen_mcu);
        grant[0] = want[0] && !(same && (acc[1] || (want[1] && mcu_first)));
        grant[1] = want[1] && !(same && (acc[0] || (want[0] && !mcu_first)));
        next_sen_mcu = sen_mcu;
        if (st[1] == ARB_IDLE && req[1] && !grant[1] && !wt[0]) begin
            next_sen_mcu = 1'b1;
        end
        if (st[0] == ARB_IDLE && req[0] && !grant[0] && !wt[1]) begin
            next_sen_mcu = 1'b0;
        end
        for (int p = 0; p < 2; p++) begin
            case (st[p])
                ARB_IDLE: begin
                    if (req[p]) begin
                        next_st[p] = grant[p] ? ARB_ACCESS : ARB_WAIT;
                    end else begin
                        next_st[p] = ARB_IDLE;
                    end
                end
                ARB_WAIT: next_st[p] = grant[p] ? ARB_ACCESS : ARB_WAIT;
                ARB_ACCESS: next_st[p] = ARB_DONE;
                ARB_DONE: next_st[p] = req[p] ? ARB_DONE : ARB_IDLE;
                default: next_st[p] = ARB_IDLE;
            endcase
        end
    end

    // arbiter registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st[0] <= ARB_IDLE;
            st[1] <= ARB_IDLE;
            sen_mcu <= 1'b0;
        end else begin
            st[0] <= next_st[0];
            st[1] <= next_st[1];
            sen_mcu <= next_sen_mcu;
        end
    end

    // handshake holds until the requester drops its request
    assign HOST_RAM_HANDSHAKE = (st[0] == ARB_DONE);
    assign MCU_ACK = (st[1] == ARB_DONE);

    thh_msg_ram u_ram (
        .clk(MCLK),
        .a_en(acc[0]),
        .a_we(acc[0] && HOST_WE),
        .a_addr(HOST_ADDR),
        .a_wdata(HOST_WDATA),
        .a_rdata(HOST_RDATA),
        .b_en(acc[1]),
        .b_we(acc[1] && MCU_WE),
        .b_addr(MCU_ADDR),
        .b_wdata(MCU_WDATA),
        .b_rdata(MCU_RDATA)
    );

    // ------------------------------------------------------------------
    // paddle board latches and ringing monitor
    // ------------------------------------------------------------------
    logic [7:0] hook, next_hook, ground, next_ground, next_txmute;
    logic [15:0] mon, next_mon;
    logic [7:0] io_rdata, next_io_rdata, ring, next_ring;
    logic io_oe, next_io_oe;

    // latch writes, identity on reads, ringing pair select
    always_comb begin
        next_hook = hook;
        next_ground = ground;
        next_txmute = txmute;
        next_mon = mon;
        if (IO_WR) begin
            case (IO_ADDR)
                IO_HOOK: next_hook = IO_WDATA;
                IO_GROUND: next_ground = IO_WDATA;
                IO_TXMUTE: next_txmute = IO_WDATA;
                IO_MON_LO: next_mon[7:0] = IO_WDATA;
                IO_MON_HI: next_mon[15:8] = IO_WDATA;
                default: next_hook = hook;
            endcase
        end
        next_io_rdata = IO_RD ? BOARD_ID : io_rdata;
        next_io_oe = IO_RD;
        for (int k = 0; k < PCM_SLOTS; k++) begin
            case (mon[2*k +: 2])
                MON_TR: next_ring[k] = RING_TR[k];
                MON_TG: next_ring[k] = RING_TG[k];
                MON_RG: next_ring[k] = RING_RG[k];
                default: next_ring[k] = 1'b0;
            endcase
        end
    end

    // latch registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            hook <= HOOK_RST;
            ground <= GROUND_RST;
            txmute <= TXMUTE_RST;
            mon <= MON_RST;
            io_rdata <= 8'h00;
            io_oe <= 1'b0;
            ring <= 8'h00;
        end else begin
            hook <= next_hook;
            ground <= next_ground;
            txmute <= next_txmute;
            mon <= next_mon;
            io_rdata <= next_io_rdata;
            io_oe <= next_io_oe;
            ring <= next_ring;
        end
    end

    assign RELAY_HOOK = hook;
    assign RELAY_GROUND = ground;
    assign RING_MON_SEL = mon;
    assign IO_RDATA = io_rdata;
    assign IO_RDATA_OE = io_oe;
    assign RING_DETECT = ring;

endmodule // thh_top
`default_nettype wire

/* File: testbench/test_head_host_interface_bench.sv */
// Self-checking bench for the test head host interface.
// Assumes the host model feeds the pcm window; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module test_head_host_interface_bench;
    import thh_pkg::*;
    localparam logic [7:0] ID = 8'h3C; // arbitrary identity value
    localparam logic [79:0] PAT = 80'hA5C3_0F96_E178_3CD2_4B1E;
    logic MCLK, RST_B, PCM_BIT_EN, PCM_FRAME_WINDOW_N, PCM_INBOUND_STREAM;
    logic PCM_OUTBOUND_DATA, PCM_OUTBOUND_OE, CODEC_RX_DATA, HOST_REQ;
    logic HOST_WE, HOST_RAM_HANDSHAKE, MCU_REQ, MCU_WE, MCU_ACK, IO_RD, IO_WR;
    logic IO_RDATA_OE, start;
    logic [2:0] IO_ADDR;
    logic [10:0] HOST_ADDR, MCU_ADDR;
    logic [15:0] RING_MON_SEL;
    logic [7:0] CODEC_SLOT_ENABLE, CODEC_TX_DATA, HOST_WDATA, HOST_RDATA;
    logic [7:0] MCU_WDATA, MCU_RDATA, IO_WDATA, IO_RDATA, RELAY_HOOK;
    logic [7:0] RELAY_GROUND, RING_TR, RING_TG, RING_RG, RING_DETECT;
    int mismatches = 0;
    int tests_run = 0;

    thh_top #(.BOARD_ID(ID)) DUT (
        .MCLK, .RST_B, .PCM_BIT_EN, .PCM_FRAME_WINDOW_N, .PCM_INBOUND_STREAM,
        .PCM_OUTBOUND_DATA, .PCM_OUTBOUND_OE, .CODEC_SLOT_ENABLE,
        .CODEC_RX_DATA, .CODEC_TX_DATA, .HOST_REQ, .HOST_WE, .HOST_ADDR,
        .HOST_WDATA, .HOST_RDATA, .HOST_RAM_HANDSHAKE, .MCU_REQ, .MCU_WE,
        .MCU_ADDR, .MCU_WDATA, .MCU_RDATA, .MCU_ACK, .IO_RD, .IO_WR, .IO_ADDR,
        .IO_WDATA, .IO_RDATA, .IO_RDATA_OE, .RELAY_HOOK, .RELAY_GROUND,
        .RING_MON_SEL, .RING_TR, .RING_TG, .RING_RG, .RING_DETECT);
    thh_host_model host (.clk(MCLK), .rst_b(RST_B), .start, .pat(PAT),
        .bit_en(PCM_BIT_EN), .window_n(PCM_FRAME_WINDOW_N),
        .stream(PCM_INBOUND_STREAM));

    // 40 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // wait for a port's handshake to reach lvl, bounded
    task automatic wait_ack(input logic m, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge MCLK);
            #1;
            n++;
        end while ((m ? MCU_ACK : HOST_RAM_HANDSHAKE) !== lvl && n < 20);
        if ((m ? MCU_ACK : HOST_RAM_HANDSHAKE) !== lvl) begin
            mismatches++;
            end_sim();
        end
    endtask

    // one four-phase memory cycle on host (m=0) or mcu (m=1) port
    task automatic ram_acc(input logic m, we, input logic [10:0] a,
        input logic [7:0] d, output logic [7:0] q, output int n);
        int k;
        @(posedge MCLK);
        if (m) {MCU_WE, MCU_ADDR, MCU_WDATA, MCU_REQ} <= {we, a, d, 1'b1};
        else {HOST_WE, HOST_ADDR, HOST_WDATA, HOST_REQ} <= {we, a, d, 1'b1};
        wait_ack(m, 1'b1, n);
        q = m ? MCU_RDATA : HOST_RDATA;
        @(posedge MCLK);
        if (m) MCU_REQ <= 1'b0;
        else HOST_REQ <= 1'b0;
        wait_ack(m, 1'b0, k);
    endtask

    task automatic io_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge MCLK);
        {IO_WR, IO_ADDR, IO_WDATA} <= {1'b1, a, d};
        @(posedge MCLK);
        IO_WR <= 1'b0;
        #1;
    endtask

    // one full window with loop 1 muted (its transmit bit is 1)
    task automatic t_pcm();
        int s;
        io_wr(IO_TXMUTE, 8'h02);
        @(posedge MCLK);
        start <= 1'b1;
        @(posedge MCLK);
        start <= 1'b0;
        for (int i = 0; i < 80; i++) begin
            s = i / 10;
            @(posedge MCLK);
            #1;
            if (i % 10 < 8) begin
                chk(CODEC_SLOT_ENABLE, 8'h01 << s);
                chk(CODEC_RX_DATA, PAT[79 - i]);
                chk({PCM_OUTBOUND_OE, PCM_OUTBOUND_DATA},
                    {1'b1, s == 1 ? 1'b1 : CODEC_TX_DATA[s]});
            end else begin
                chk({CODEC_SLOT_ENABLE, PCM_OUTBOUND_OE}, 9'h000);
            end
        end
        @(posedge MCLK);
        #1;
        chk(CODEC_SLOT_ENABLE, 8'h00);
    endtask

    // both ports, plain then clashing on one address
    task automatic t_ram();
        logic [7:0] q;
        int n;
        ram_acc(1'b0, 1'b1, 11'h7FF, 8'hA5, q, n);
        chk(16'(n), 16'h0002);
        ram_acc(1'b1, 1'b1, 11'h000, 8'h5C, q, n);
        ram_acc(1'b1, 1'b0, 11'h7FF, 8'h00, q, n);
        chk(q, 8'hA5);
        ram_acc(1'b0, 1'b0, 11'h000, 8'h00, q, n);
        chk(q, 8'h5C);
        @(posedge MCLK);
        {HOST_WE, HOST_ADDR, HOST_WDATA, HOST_REQ} <= {1'b1, 11'h123, 8'h11, 1'b1};
        {MCU_WE, MCU_ADDR, MCU_WDATA, MCU_REQ} <= {1'b1, 11'h123, 8'h22, 1'b1};
        wait_ack(1'b0, 1'b1, n);
        chk({n[7:0], MCU_ACK}, 9'h004);
        @(posedge MCLK);
        HOST_REQ <= 1'b0;
        wait_ack(1'b1, 1'b1, n);
        @(posedge MCLK);
        MCU_REQ <= 1'b0;
        wait_ack(1'b1, 1'b0, n);
        ram_acc(1'b0, 1'b0, 11'h123, 8'h00, q, n);
        chk(q, 8'h22);
        // microcontroller first on one address, host a cycle later
        @(posedge MCLK);
        {MCU_WE, MCU_ADDR, MCU_WDATA, MCU_REQ} <= {1'b1, 11'h456, 8'h33, 1'b1};
        @(posedge MCLK);
        {HOST_WE, HOST_ADDR, HOST_WDATA, HOST_REQ} <= {1'b1, 11'h456, 8'h44, 1'b1};
        wait_ack(1'b1, 1'b1, n);
        chk({n[7:0], HOST_RAM_HANDSHAKE}, 9'h002);
        wait_ack(1'b0, 1'b1, n);
        chk(16'(n), 16'h0002);
        @(posedge MCLK);
        {HOST_REQ, MCU_REQ} <= 2'b00;
        wait_ack(1'b0, 1'b0, n);
        ram_acc(1'b1, 1'b0, 11'h456, 8'h00, q, n);
        chk(q, 8'h44);
    endtask

    // latches, identity read, ringing monitor selection
    task automatic t_io();
        chk({RELAY_HOOK, RELAY_GROUND}, 16'h0000);
        io_wr(IO_HOOK, 8'h81);
        io_wr(IO_GROUND, 8'h3C);
        io_wr(3'h5, 8'hFF);
        chk({RELAY_HOOK, RELAY_GROUND}, 16'h813C);
        @(posedge MCLK);
        IO_RD <= 1'b1;
        @(posedge MCLK);
        IO_RD <= 1'b0;
        #1;
        chk({IO_RDATA_OE, IO_RDATA}, {1'b1, ID});
        @(posedge MCLK);
        #1;
        chk({IO_RDATA_OE, IO_RDATA}, {1'b0, ID});
        io_wr(IO_MON_LO, 8'hE4);
        io_wr(IO_MON_HI, 8'h1B);
        chk(RING_MON_SEL, 16'h1BE4);
        @(posedge MCLK);
        {RING_TR, RING_TG, RING_RG} <= {8'hFE, 8'h02, 8'h04};
        repeat (2) @(posedge MCLK);
        #1;
        chk(RING_DETECT, 8'h86);
        @(posedge MCLK);
        {RING_TR, RING_TG, RING_RG} <= {8'h01, 8'hFD, 8'hFB};
        repeat (2) @(posedge MCLK);
        #1;
        chk(RING_DETECT, 8'h61);
    endtask

    // reset, then each scenario in turn
    initial begin
        RST_B = 1'b0;
        start = 1'b0;
        CODEC_TX_DATA = 8'hA5;
        {HOST_REQ, HOST_WE, HOST_ADDR, HOST_WDATA} = '0;
        {MCU_REQ, MCU_WE, MCU_ADDR, MCU_WDATA} = '0;
        {IO_RD, IO_WR, IO_ADDR, IO_WDATA} = '0;
        {RING_TR, RING_TG, RING_RG} = '0;
        repeat (16) @(posedge MCLK);
        RST_B <= 1'b1;
        t_io();
        t_pcm();
        t_ram();
        end_sim();
    end
endmodule // test_head_host_interface_bench
`default_nettype wire

/* File: testbench/thh_host_model.sv */
// Host side pcm source: one 80-bit low window, one bit per MCLK.
// Assumes the bench pulses start for one cycle while the model is idle.
`timescale 1ns/1ps
`default_nettype none
module thh_host_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [79:0] pat,
    output logic bit_en,
    output logic window_n,
    output logic stream
);
    logic [6:0] cnt;
    // bit position in the window, 80 means idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 7'h50;
        end else if (start) begin
            cnt <= 7'h00;
        end else if (cnt < 7'h50) begin
            cnt <= cnt + 7'h01;
        end
    end
    // window held low for exactly 80 bit pulses, first bit is pat msb
    assign window_n = (cnt >= 7'h50);
    assign bit_en = !window_n;
    // idle line shows the inverse of the last bit, not a stale copy
    assign stream = window_n ? ~pat[0] : pat[7'h4F - cnt];
endmodule // thh_host_model
`default_nettype wire

/* File: testbench/thh_top_props.sv */
// Port checks for the test head host interface.
// Assumes one clock, MCLK, and the active low reset RST_B.
`timescale 1ns/1ps
`default_nettype none
module thh_top_props
    import thh_pkg::*;
#(
    parameter logic [7:0] BOARD_ID = 8'h5A // arbitrary identity value
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic PCM_BIT_EN,
    input wire logic PCM_FRAME_WINDOW_N,
    input wire logic PCM_INBOUND_STREAM,
    input wire logic PCM_OUTBOUND_OE,
    input wire logic [7:0] CODEC_SLOT_ENABLE,
    input wire logic CODEC_RX_DATA,
    input wire logic HOST_REQ,
    input wire logic HOST_RAM_HANDSHAKE,
    input wire logic MCU_REQ,
    input wire logic IO_RD,
    input wire logic IO_WR,
    input wire logic [2:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic [7:0] IO_RDATA,
    input wire logic IO_RDATA_OE,
    input wire logic [7:0] RELAY_HOOK,
    input wire logic [15:0] RING_MON_SEL,
    input wire logic [7:0] RING_TR,
    input wire logic [7:0] RING_TG,
    input wire logic [7:0] RING_RG,
    input wire logic [7:0] RING_DETECT
);
    logic ring0;
    // detector level that loop 0's monitor selection points at
    assign ring0 = (RING_MON_SEL[1:0] == MON_TR) ? RING_TR[0] :
        (RING_MON_SEL[1:0] == MON_TG) ? RING_TG[0] :
        (RING_MON_SEL[1:0] == MON_RG) ? RING_RG[0] : 1'b0;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    property p_onehot; $onehot0(CODEC_SLOT_ENABLE); endproperty
    a_onehot: assert property (p_onehot) else $error("slot overlap");
    property p_win; PCM_FRAME_WINDOW_N |=> CODEC_SLOT_ENABLE == 8'h00;
    endproperty
    a_win: assert property (p_win) else $error("slot outside window");
    property p_oe; PCM_OUTBOUND_OE == (|CODEC_SLOT_ENABLE); endproperty
    a_oe: assert property (p_oe) else $error("drive outside slot");
    property p_rx; (PCM_BIT_EN && !PCM_FRAME_WINDOW_N ##1 (|CODEC_SLOT_ENABLE))
        |-> CODEC_RX_DATA == $past(PCM_INBOUND_STREAM); endproperty
    a_rx: assert property (p_rx) else $error("inbound bit lost");
    property p_hs; $rose(HOST_REQ) && !$past(MCU_REQ) |-> ##2
        HOST_RAM_HANDSHAKE; endproperty
    a_hs: assert property (p_hs) else $error("host not paced");
    property p_id; IO_RD |=> IO_RDATA_OE && IO_RDATA == BOARD_ID; endproperty
    a_id: assert property (p_id) else $error("identity not read");
    property p_hook; IO_WR && IO_ADDR == IO_HOOK |=>
        RELAY_HOOK == $past(IO_WDATA); endproperty
    a_hook: assert property (p_hook) else $error("hook not latched");
    property p_ring; 1'b1 |=> RING_DETECT[0] == $past(ring0); endproperty
    a_ring: assert property (p_ring) else $error("ring wrong");
endmodule // thh_top_props

bind thh_top thh_top_props #(.BOARD_ID(BOARD_ID)) u_props (
    .MCLK, .RST_B, .PCM_BIT_EN, .PCM_FRAME_WINDOW_N, .PCM_INBOUND_STREAM,
    .PCM_OUTBOUND_OE, .CODEC_SLOT_ENABLE, .CODEC_RX_DATA, .HOST_REQ,
    .HOST_RAM_HANDSHAKE, .MCU_REQ, .IO_RD, .IO_WR, .IO_ADDR, .IO_WDATA,
    .IO_RDATA, .IO_RDATA_OE, .RELAY_HOOK, .RING_MON_SEL, .RING_TR,
    .RING_TG, .RING_RG, .RING_DETECT);
`default_nettype wire
